//--- bser_map.vh
/*
 * Constants for the bus status and error reporter: register offsets,
 * error-word bit positions, user-word error codes and query selectors.
 * Assumes nothing; definitions only, included by bare name.
 */
`ifndef BSER_MAP_VH
`define BSER_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BSER_REG_CTRL     4'h0
`define BSER_REG_ERROR    4'h1
`define BSER_REG_WORDERR  4'h2
`define BSER_REG_QUERY    4'h3
`define BSER_REG_RESP     4'h4
`define BSER_REG_BUFSIZE  4'h5
`define BSER_REG_CURVAL   4'h6

// ----------------------------------------------------------------------
// Error word bit positions
// ----------------------------------------------------------------------
`define BSER_ERR_NEEDCUR  0
`define BSER_ERR_NEEDBOTH 1
`define BSER_ERR_CALLOCK  2
`define BSER_ERR_CONFLICT 3
`define BSER_ERR_NOREM    4
`define BSER_ERR_ILLCMD   5
`define BSER_ERR_ILLOPT   6
`define BSER_ERR_WORD     7
`define BSER_ERR_W        8

// ----------------------------------------------------------------------
// User-word error codes
// ----------------------------------------------------------------------
`define BSER_WE_NOMEM     8'h09
`define BSER_WE_ALIAS2    8'h14
`define BSER_WE_LONG      8'h15
`define BSER_WE_EXEC      8'h16
`define BSER_WE_DUP       8'h17
`define BSER_WE_DOLLAR    8'h18
`define BSER_WE_SEMI      8'h19
`define BSER_WE_LIST      8'h20
`define BSER_WE_ERASE_WORDS_KEYWORD    8'h21
`define BSER_WE_SAVE      8'h23
`define BSER_NAME_MAX     6'd31

// ----------------------------------------------------------------------
// Query selectors
// ----------------------------------------------------------------------
`define BSER_Q_NONE       3'h0
`define BSER_Q_WORDS      3'h2
`define BSER_Q_SIZE       3'h3
`define BSER_Q_AVG        3'h4
`define BSER_Q_MIN        3'h5
`define BSER_Q_MAX        3'h6
`define BSER_Q_CUR        3'h7

// ----------------------------------------------------------------------
// Response source tags
// ----------------------------------------------------------------------
`define BSER_SRC_READING  3'h0
`define BSER_SRC_WORDS    3'h1
`define BSER_SRC_SIZE     3'h2
`define BSER_SRC_STAT     3'h3
`define BSER_SRC_CUR      3'h4

`endif

//--- bser_reporter.v
/*
 * Bus status and error reporter: gathers command parser, calibration and
 * user-word definition error events into a sticky error word, decides
 * whether a command string may execute, and serves one-shot queries on
 * the next talk addressing (statistics once the buffer is full) before falling back to normal readings.
 * Assumes a command parser on sys_clk that classifies each string and
 * each definition event as one-cycle pulses, and a talk-address pulse
 * from the bus interface logic; REN arrives from a pin.
 */
`include "bser_map.vh"

module bser_reporter #(
    parameter DW = 32
) (
    input  wire          sys_clk,
    input  wire          rst,
    input  wire [3:0]    regAddr,
    input  wire [31:0]   regWrData,
    input  wire          regWrite,
    input  wire          regRead,
    output reg  [31:0]   regRdData,
    input  wire          renPin,
    input  wire          stringDone,
    input  wire          cmdIllegal,
    input  wire          optIllegal,
    input  wire          selDcCurrent,
    input  wire          selAcCurrent,
    input  wire          calAttempt,
    input  wire          calLockSwitch,
    input  wire          calStateBad,
    input  wire          defStore,
    input  wire          defMemFull,
    input  wire          defNameExists,
    input  wire [5:0]    defNameLen,
    input  wire [1:0]    defRenameCount,
    input  wire          defHasExec,
    input  wire          defHasDollar,
    input  wire          defHasList,
    input  wire          defHasForget,
    input  wire          defHasSave,
    input  wire          semicolonRx,
    input  wire          defModeActive,
    input  wire          bufferFull,
    input  wire [DW-1:0] statAverage,
    input  wire [DW-1:0] statMinimum,
    input  wire [DW-1:0] statMaximum,
    input  wire [DW-1:0] wordListData,
    input  wire [DW-1:0] normalReading,
    input  wire          talkAddressed,
    output reg           execString,
    output reg           discardString,
    output reg           talkValid,
    output reg  [DW-1:0] talkData,
    output reg  [2:0]    talkSource,
    output reg           remoteState
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Address match for one register; keeps each strobe qualifier short
    function regHit;
        input [3:0] addr;
        input [3:0] sel;
        regHit = (addr == sel);
    endfunction

    // Selectors whose answer depends on a completely filled buffer
    function isStatQuery;
        input [2:0] sel;
        isStatQuery = (sel == `BSER_Q_AVG) || (sel == `BSER_Q_MIN) ||
                      (sel == `BSER_Q_MAX);
    endfunction

    // ------------------------------------------------------------------
    // Remote enable synchroniser
    // ------------------------------------------------------------------
    reg renS1;
    reg renS2;
    reg renS3;

    // REN is asynchronous to sys_clk; the extra stage filters a single
    // metastable or glitchy sample before it gates whole strings.
    // remoteState starts low, so strings before REN settles are refused.
    // Three stages; the level is accepted only when stages two and three agree
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            renS1       <= 1'b0;
            renS2       <= 1'b0;
            renS3       <= 1'b0;
            remoteState <= 1'b0;
        end else begin
            renS1 <= renPin;
            renS2 <= renS1;
            renS3 <= renS2;
            if (renS2 == renS3)
                remoteState <= renS3;
        end
    end

    // ------------------------------------------------------------------
    // String acceptance
    // ------------------------------------------------------------------
    // Qualifiers are only meaningful in the stringDone cycle.
    // An illegal command masks its option fault so one cause is reported.
    wire notRemoteEvt = stringDone & ~remoteState;
    wire illCmdEvt    = stringDone & cmdIllegal;
    wire illOptEvt    = stringDone & optIllegal & ~cmdIllegal;
    wire rejectEvt    = notRemoteEvt | illCmdEvt | illOptEvt;

    // Whole string is dropped on any parse or remote fault
    // Exactly one of execString and discardString pulses per string;
    // the flags and the discard pulse appear in the same later cycle.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            execString    <= 1'b0;
            discardString <= 1'b0;
        end else begin
            execString    <= stringDone & ~rejectEvt;
            discardString <= rejectEvt;
        end
    end

    // ------------------------------------------------------------------
    // User-word definition checks
    // ------------------------------------------------------------------
    reg [7:0] wordCode;
    reg       wordEvt;

    // Priority picks one code per event; storage exhaustion is checked last
    // because a malformed definition would never have reached memory.
    // The semicolon check stands first: it needs no definition strobe.
    // Name length is checked before content so an oversized name is
    // reported once, whatever it holds. Only one code is kept per event.
    always @* begin
        wordEvt  = 1'b1;
        wordCode = 8'h00;
        if (semicolonRx && defModeActive)
            wordCode = `BSER_WE_SEMI;
        else if (!defStore)
            wordEvt = 1'b0;
        else if (defNameLen > `BSER_NAME_MAX)
            wordCode = `BSER_WE_LONG;
        else if (defRenameCount > 2'd1)
            wordCode = `BSER_WE_ALIAS2;
        else if (defHasExec)
            wordCode = `BSER_WE_EXEC;
        else if (defHasDollar)
            wordCode = `BSER_WE_DOLLAR;
        else if (defHasList)
            wordCode = `BSER_WE_LIST;
        else if (defHasForget)
            wordCode = `BSER_WE_ERASE_WORDS_KEYWORD;
        else if (defHasSave)
            wordCode = `BSER_WE_SAVE;
        else if (defNameExists)
            wordCode = `BSER_WE_DUP;
        else if (defMemFull)
            wordCode = `BSER_WE_NOMEM;
        else
            wordEvt = 1'b0;
    end

    // ------------------------------------------------------------------
    // Fitted options
    // ------------------------------------------------------------------
    // Software reports which options are fitted; DC current without the current option,
    // or AC current with neither option fitted, becomes an error instead of a measurement.
    reg          optCurrent;
    reg          optAcVolt;

    // ------------------------------------------------------------------
    // Sticky error word
    // ------------------------------------------------------------------
    reg [`BSER_ERR_W-1:0] errFlags;
    reg [7:0]             wordErrCode;
    reg [`BSER_ERR_W-1:0] setVec;

    // Set vector: one bit per event class, all evaluated every cycle.
    // Only the fault is recorded; what runs is the parser's business.
    always @* begin
        setVec = {`BSER_ERR_W{1'b0}};
        setVec[`BSER_ERR_NEEDCUR]  = selDcCurrent & ~optCurrent;
        setVec[`BSER_ERR_NEEDBOTH] = selAcCurrent & ~optAcVolt
                                     & ~optCurrent;
        setVec[`BSER_ERR_CALLOCK]  = calAttempt & calLockSwitch;
        setVec[`BSER_ERR_CONFLICT] = calAttempt & calStateBad;
        setVec[`BSER_ERR_NOREM]    = notRemoteEvt;
        setVec[`BSER_ERR_ILLCMD]   = illCmdEvt;
        setVec[`BSER_ERR_ILLOPT]   = illOptEvt;
        setVec[`BSER_ERR_WORD]     = wordEvt;
    end

    wire errRead = regRead && regHit(regAddr, `BSER_REG_ERROR);

    // Reading the error word clears what it reported; a new event that
    // lands in the same cycle survives, so nothing is lost to the clear.
    // The code register keeps only the newest code; older ones are lost.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            errFlags    <= {`BSER_ERR_W{1'b0}};
            wordErrCode <= 8'h00;
        end else begin
            if (errRead)
                errFlags <= setVec;
            else
                errFlags <= errFlags | setVec;
            if (wordEvt)
                wordErrCode <= wordCode;
            else if (errRead)
                wordErrCode <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Control registers written by software
    // ------------------------------------------------------------------
    reg [DW-1:0] bufSize;
    reg [DW-1:0] curValue;
    reg [2:0]    pendQuery;

    wire qWrite = regWrite && regHit(regAddr, `BSER_REG_QUERY);

    // Option bits, buffer size and held value come from software.
    // The held value may be a calibration, zero or compensation figure.
    // Writes to read-only offsets are ignored.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            optCurrent <= 1'b0;
            optAcVolt  <= 1'b0;
            bufSize    <= {DW{1'b0}};
            curValue   <= {DW{1'b0}};
        end else if (regWrite) begin
            case (regAddr)
                `BSER_REG_CTRL: begin
                    optCurrent <= regWrData[0];
                    optAcVolt  <= regWrData[1];
                end
                `BSER_REG_BUFSIZE: bufSize  <= regWrData[DW-1:0];
                `BSER_REG_CURVAL:  curValue <= regWrData[DW-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // One-shot query delivery
    // ------------------------------------------------------------------
    wire statQuery = isStatQuery(pendQuery);
    // Statistics stay pending across talks until the buffer has filled;
    // a withheld statistic leaves the pending selector untouched.
    wire statHeld  = statQuery && !bufferFull;
    wire oneShot   = (pendQuery != `BSER_Q_NONE) && !statHeld;

    // Response mux: pending one-shot first, normal reading otherwise
    reg [DW-1:0] next_talkData;
    reg [2:0]    next_talkSource;

    always @* begin
        next_talkData   = normalReading;
        next_talkSource = `BSER_SRC_READING;
        if (oneShot) begin
            case (pendQuery)
                `BSER_Q_WORDS: begin
                    next_talkData   = wordListData;
                    next_talkSource = `BSER_SRC_WORDS;
                end
                `BSER_Q_SIZE: begin
                    next_talkData   = bufSize;
                    next_talkSource = `BSER_SRC_SIZE;
                end
                `BSER_Q_AVG: begin
                    next_talkData   = statAverage;
                    next_talkSource = `BSER_SRC_STAT;
                end
                `BSER_Q_MIN: begin
                    next_talkData   = statMinimum;
                    next_talkSource = `BSER_SRC_STAT;
                end
                `BSER_Q_MAX: begin
                    next_talkData   = statMaximum;
                    next_talkSource = `BSER_SRC_STAT;
                end
                `BSER_Q_CUR: begin
                    next_talkData   = curValue;
                    next_talkSource = `BSER_SRC_CUR;
                end
                // Selector 1 has no one-shot of its own here: a reading
                default: begin
                    next_talkData   = normalReading;
                    next_talkSource = `BSER_SRC_READING;
                end
            endcase
        end
    end

    // A delivered query is retired so the following talk gives a reading.
    // A new query written in the delivering cycle replaces the retirement.
    // talkData holds between talks so a slow reader sees a stable word.
    // talkSource records what the last answer carried for software.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pendQuery  <= `BSER_Q_NONE;
            talkValid  <= 1'b0;
            talkData   <= {DW{1'b0}};
            talkSource <= `BSER_SRC_READING;
        end else begin
            // Every talk answers, with a one-shot or with a reading
            talkValid <= talkAddressed;
            if (talkAddressed) begin
                talkData   <= next_talkData;
                talkSource <= next_talkSource;
            end
            if (qWrite)
                pendQuery <= regWrData[2:0];
            else if (talkAddressed && oneShot)
                pendQuery <= `BSER_Q_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Unmapped offsets and idle cycles read as zero, so stale data never
    // lingers on the bus. Reading the error word also clears it above.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                `BSER_REG_CTRL:    regRdData <= {30'h0, optAcVolt, optCurrent};
                `BSER_REG_ERROR:   regRdData <= {{(32-`BSER_ERR_W){1'b0}}, errFlags};
                `BSER_REG_WORDERR: regRdData <= {24'h0, wordErrCode};
                `BSER_REG_QUERY:   regRdData <= {29'h0, pendQuery};
                `BSER_REG_RESP:    regRdData <= {24'h0, 3'h0, remoteState,
                                                 1'b0, talkSource};
                `BSER_REG_BUFSIZE: regRdData <= bufSize;
                `BSER_REG_CURVAL:  regRdData <= curValue;
                default:           regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule

//--- bser_checker.sv
/* Concurrent checks on the reporter's top-level ports.
   Assumes one sys_clk domain with rst asynchronous, active high. */
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module bser_checker #(
    parameter DW = 32
) (
    input logic          sys_clk,
    input logic          rst,
    input logic          stringDone,
    input logic          cmdIllegal,
    input logic          optIllegal,
    input logic          remoteState,
    input logic          execString,
    input logic          discardString,
    input logic          talkAddressed,
    input logic          talkValid,
    input logic [2:0]    talkSource,
    input logic [DW-1:0] talkData,
    input logic          bufferFull,
    input logic [DW-1:0] normalReading,
    input logic [DW-1:0] wordListData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // A clean string from a remote controller runs
    chk_exec_clean: assert property (
        stringDone && !cmdIllegal && !optIllegal && remoteState |=> execString && !discardString)
        else $error("clean string not executed");
    // Any parser or remote fault throws the whole string away
    chk_discard_fault: assert property (
        stringDone && (cmdIllegal || optIllegal || !remoteState) |=> discardString && !execString)
        else $error("faulty string not discarded");
    chk_exec_cause: assert property (
        execString |-> !discardString && $past(stringDone))
        else $error("execute without a finished string");
    chk_talk_answer: assert property (
        talkAddressed |=> talkValid)
        else $error("talk addressing not answered");
    chk_talk_cause: assert property (
        talkValid |-> $past(talkAddressed))
        else $error("talk answer without addressing");
    chk_normal_data: assert property (
        talkValid && talkSource == 3'h0 |-> talkData == $past(normalReading))
        else $error("normal reading data wrong");
    chk_words_data: assert property (
        talkValid && talkSource == 3'h1 |-> talkData == $past(wordListData))
        else $error("word list data wrong");
    // Statistics must never leave before the buffer is full
    chk_stat_hold: assert property (
        talkAddressed && !bufferFull |=> talkSource != 3'h3)
        else $error("statistic sent from a partial buffer");
    chk_stat_gate: assert property (
        talkValid && talkSource == 3'h3 |-> $past(bufferFull))
        else $error("statistic without full buffer");
endmodule

bind bser_reporter bser_checker #(.DW(DW)) u_chk (
    .sys_clk, .rst, .stringDone, .cmdIllegal, .optIllegal, .remoteState,
    .execString, .discardString, .talkAddressed, .talkValid, .talkSource,
    .talkData, .bufferFull, .normalReading, .wordListData
);

//--- bser_bus_ctrl.sv
/* Model of the bus controller: remote enable, parsed strings, talk addressing.
   Assumes the reporter samples on the rising edge of sys_clk. */
// ----------------------------------------------------------------
// Controller model
// ----------------------------------------------------------------
module bser_bus_ctrl (
    input  logic sys_clk,
    output logic renPin = 1'b0,
    output logic stringDone = 1'b0,
    output logic cmdIllegal = 1'b1,
    output logic optIllegal = 1'b1,
    output logic talkAddressed = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Remote enable is a slow pin; wait out the synchroniser
    task set_remote(input logic on);
        @(posedge sys_clk);
        renPin <= on;
        repeat (6) @(posedge sys_clk);
    endtask

    // Qualifiers flip after the strobe so stale levels are never trusted
    task send_string(input logic ill, input logic opt);
        @(posedge sys_clk);
        stringDone <= 1'b1;
        cmdIllegal <= ill;
        optIllegal <= opt;
        @(posedge sys_clk);
        stringDone <= 1'b0;
        cmdIllegal <= ~ill;
        optIllegal <= ~opt;
    endtask

    task address_talk;
        @(posedge sys_clk);
        talkAddressed <= 1'b1;
        @(posedge sys_clk);
        talkAddressed <= 1'b0;
    endtask
endmodule

//--- bser_tb.sv
/* Self-checking bench for the status and error reporter.
   Assumes the controller model and the bound checker are compiled alongside. */
`include "bser_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Stimulus and wiring
    // ----------------------------------------------------------------
    localparam logic [31:0] AVG = 32'h0000_0a01, MINV = 32'h0000_0a02;
    localparam logic [31:0] MAXV = 32'h0000_0a03, WORDS = 32'h0000_0b0b;
    localparam logic [31:0] NORM = 32'h0000_0d0d;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [3:0]  ev = 4'h0;     // dc, ac, cal attempt, semicolon
    logic [1:0]  calQ = 2'h0;   // lock switch, bad state
    logic [8:0]  defQ = 9'h0;   // store, full, exists, exec..save, def mode
    logic [5:0]  defNameLen = 6'h05;
    logic [1:0]  defRenameCount = 2'h1;
    logic        bufferFull = 1'b0;
    logic        renPin, stringDone, cmdIllegal, optIllegal, talkAddressed;
    logic        execString, discardString, talkValid, remoteState;
    logic [31:0] regRdData, talkData;
    logic [2:0]  talkSource;
    int          n_errors = 0;
    int          checks_done = 0;

    bser_reporter #(.DW(32)) dut (
        .sys_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .renPin, .stringDone, .cmdIllegal, .optIllegal,
        .selDcCurrent(ev[0]), .selAcCurrent(ev[1]), .calAttempt(ev[2]),
        .calLockSwitch(calQ[0]), .calStateBad(calQ[1]), .defStore(defQ[0]),
        .defMemFull(defQ[1]), .defNameExists(defQ[2]), .defNameLen, .defRenameCount,
        .defHasExec(defQ[3]), .defHasDollar(defQ[4]), .defHasList(defQ[5]),
        .defHasForget(defQ[6]), .defHasSave(defQ[7]), .semicolonRx(ev[3]),
        .defModeActive(defQ[8]), .bufferFull, .statAverage(AVG), .statMinimum(MINV),
        .statMaximum(MAXV), .wordListData(WORDS), .normalReading(NORM), .talkAddressed,
        .execString, .discardString, .talkValid, .talkData, .talkSource, .remoteState
    );
    bser_bus_ctrl ctl (.sys_clk, .renPin, .stringDone, .cmdIllegal, .optIllegal, .talkAddressed);

    initial forever #5 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 cmp(regRdData, exp);
    endtask
    task pulse(input int b);
        @(posedge sys_clk);
        ev[b] <= 1'b1;
        @(posedge sys_clk);
        ev[b] <= 1'b0;
    endtask
    task talk(input logic [2:0] src, input logic [31:0] data);
        ctl.address_talk();
        #1 cmp({31'h0, talkValid}, 32'h1);
        cmp({29'h0, talkSource}, {29'h0, src});
        cmp(talkData, data);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_strings;
        logic [2:0]  c [5] = '{3'b001, 3'b101, 3'b011, 3'b111, 3'b000}; // ill, opt, ren
        logic [31:0] e [5] = '{32'h00, 32'h20, 32'h40, 32'h20, 32'h10};
        for (int i = 0; i < 5; i++) begin
            ctl.set_remote(c[i][0]);
            ctl.send_string(c[i][2], c[i][1]);
            #1 cmp({30'h0, execString, discardString}, (i == 0) ? 32'h2 : 32'h1);
            rd(`BSER_REG_ERROR, e[i]);
        end
        ctl.set_remote(1'b1);
    endtask
    task t_options;
        wr(`BSER_REG_CTRL, 32'h0);
        pulse(0);
        rd(`BSER_REG_ERROR, 32'h01);
        rd(`BSER_REG_ERROR, 32'h00);
        pulse(1);
        rd(`BSER_REG_ERROR, 32'h02);
        wr(`BSER_REG_CTRL, 32'h3);
        pulse(0);
        pulse(1);
        rd(`BSER_REG_ERROR, 32'h00);
    endtask
    task t_cal;
        logic [1:0]  q [3] = '{2'h1, 2'h2, 2'h0};
        logic [31:0] e [3] = '{32'h04, 32'h08, 32'h00};
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            calQ <= q[i];
            pulse(2);
            rd(`BSER_REG_ERROR, e[i]);
        end
    endtask
    // One fault per definition; the last case is a name of exactly the limit
    task t_words;
        logic [7:0] code [11] = '{8'h09, 8'h15, 8'h14, 8'h16, 8'h18, 8'h20,
                                  8'h21, 8'h23, 8'h17, 8'h19, 8'h00};
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            defNameLen <= (i == 1) ? 6'd32 : (i == 10) ? 6'd31 : 6'd5;
            defRenameCount <= (i == 2) ? 2'h2 : 2'h1;
            defQ <= (i == 9) ? 9'h100 : 9'h1 | ((i == 0) ? 9'h2 : (i == 8) ? 9'h4 :
                    (i > 2 && i < 8) ? 9'h1 << i : 9'h0);
            ev[3] <= (i == 9);
            @(posedge sys_clk);
            defQ <= 9'h0;
            ev[3] <= 1'b0;
            rd(`BSER_REG_WORDERR, {24'h0, code[i]});
            rd(`BSER_REG_ERROR, (i == 10) ? 32'h0 : 32'h80);
        end
    endtask
    task t_query;
        logic [2:0]  s [6] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4};
        logic [31:0] d [6] = '{WORDS, 32'h40, AVG, MINV, MAXV, 32'hc0c};
        wr(`BSER_REG_BUFSIZE, 32'h40);
        wr(`BSER_REG_CURVAL, 32'hc0c);
        wr(`BSER_REG_QUERY, 32'h4);
        talk(3'h0, NORM);
        @(posedge sys_clk);
        bufferFull <= 1'b1;
        talk(3'h3, AVG);
        for (int i = 0; i < 6; i++) begin
            wr(`BSER_REG_QUERY, i + 2);
            talk(s[i], d[i]);
            talk(3'h0, NORM);
        end
        rd(`BSER_REG_BUFSIZE, 32'h40);
        rd(`BSER_REG_QUERY, 32'h0);
        rd(`BSER_REG_RESP, 32'h10);
        rd(4'hf, 32'h0);
    endtask

    task tally_and_finish;
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_strings;
        t_options;
        t_cal;
        t_words;
        t_query;
        tally_and_finish;
    end
    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200us;
        n_errors++;
        tally_and_finish;
    end
endmodule
